// ---- fci_ctrl_irq.sv ----
// carrier pattern generator, interrupt unit and data acknowledge with an axi4-lite register slave
//****************************************************************
// Operation
// - carrier out pair: pattern and its inverse
// - pattern store 1024 bits, first write fills 16
// - each write shifts up 16, new LSBs
// - length code holds pattern length minus one
// - bit rate is clock over divider
// - generator runs only while enabled
// - cal bit starts polarity match, demod reference
// - success clears cal bit, fail keeps it
// - comparator flags set with global and own enable
// - comparator flag clears on read if source gone
// - watchdog flags modulator clock below clk/64
// - clock fail flag clears on read after recovery
// - comparator and clock fail flags drive irq pin (ready flags do not), polarity selectable
// - data pin active while any ready flag
// - ready polarity bit inverts data pin
// - no ready flag when filter and integrator off
// - ready enable low suppresses ready flag
// - no ready flag when both ratios one
// - status word layout, reset zero
//****************************************************************
//
// The address map and the AXI4-Lite slave port were decided locally.
`include "fci_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module fci_ctrl_irq #(
   parameter int ADDR_W = 9,
   parameter int PAT_LEN = 1024,
   parameter int N_MOD = 4
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic [N_MOD-1:0] high_cmp_hit,
   input wire logic [N_MOD-1:0] low_cmp_hit,
   input wire logic [N_MOD-1:0] mod_clk,
   input wire logic [N_MOD-1:0] data_new,
   input wire logic [N_MOD-1:0] filt_enabled,
   input wire logic [N_MOD-1:0] integ_enabled,
   input wire logic [N_MOD-1:0] osr_both_one,
   input wire logic [32*N_MOD-1:0] data_words,
   input wire logic filt_polarity,
   output logic carrier_out_true,
   output logic carrier_out_comp,
   output logic demod_ref,
   output logic irq_output_pin,
   output logic new_data_pin
);
   import fci_pkg::*;

   localparam int PW = $clog2(PAT_LEN);

   //****************************************************************
   // helpers
   //****************************************************************
   function automatic logic [6:0] idx_of(input logic [ADDR_W-1:0] a);
      idx_of = a[8:2];
   endfunction

   function automatic logic is_mod_reg(input logic [6:0] idx, input logic [6:0] base, input int m);
      is_mod_reg = (idx == 7'(base + 7'(m) * `FCI_MOD_STRIDE));
   endfunction

   function automatic fci_word16_t merge16(input fci_word16_t old, input logic [31:0] d, input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   //****************************************************************
   // axi4-lite slave
   //****************************************************************
   logic aw_got_q;
   logic w_got_q;
   logic [6:0] aw_idx_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic do_wr;
   logic do_rd;
   logic [6:0] rd_idx;
   logic [31:0] rd_val;

   assign s_axi_awready = ~aw_got_q & ~bvalid_q;
   assign s_axi_wready = ~w_got_q & ~bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = `FCI_RESP_OKAY;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = `FCI_RESP_OKAY;
   assign do_wr = aw_got_q & w_got_q;
   assign do_rd = s_axi_arvalid & ~rvalid_q;
   assign rd_idx = idx_of(s_axi_araddr);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         aw_got_q <= 1'b0;
         aw_idx_q <= 7'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_got_q <= 1'b1;
         aw_idx_q <= idx_of(s_axi_awaddr);
      end else if (do_wr) begin
         aw_got_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         w_got_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_got_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (do_wr) begin
         w_got_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bvalid_q <= 1'b0;
      end else if (do_wr) begin
         bvalid_q <= 1'b1;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else if (do_rd) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_val;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   //****************************************************************
   // configuration registers
   //****************************************************************
   fci_word16_t ctrl_q;
   logic [8:0] clkdiv_q;
   logic [N_MOD-1:0] mfie_q;
   logic [N_MOD-1:0] ae_q;
   logic [N_MOD-1:0] ieh_q;
   logic [N_MOD-1:0] iel_q;
   logic gie;
   logic [PW-1:0] plen;
   logic [7:0] div;
   logic pattern_gen_enable;
   fci_word16_t clkdiv_wr;

   assign gie = ctrl_q[`FCI_CTRL_GIE];
   assign plen = ctrl_q[`FCI_CTRL_PLEN_HI:`FCI_CTRL_PLEN_LO];
   assign div = clkdiv_q[`FCI_CLKDIV_SD_HI:0];
   assign pattern_gen_enable = clkdiv_q[`FCI_CLKDIV_SGE];
   assign clkdiv_wr = merge16({6'h00, 1'b0, clkdiv_q}, wdata_q, wstrb_q);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_q <= `FCI_RST_16;
         clkdiv_q <= 9'h000;
      end else if (do_wr && aw_idx_q == `FCI_IDX_CTRL) begin
         ctrl_q <= merge16(ctrl_q, wdata_q, wstrb_q);
      end else if (do_wr && aw_idx_q == `FCI_IDX_CLKDIV) begin
         clkdiv_q <= clkdiv_wr[8:0];
      end
   end

   // per-module enable bits, each in its module's parameter registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mfie_q <= '0;
         ae_q <= '0;
         ieh_q <= '0;
         iel_q <= '0;
      end else if (do_wr && wstrb_q[0]) begin
         for (int m = 0; m < N_MOD; m++) begin
            if (is_mod_reg(aw_idx_q, `FCI_IDX_CTLP0, m)) begin
               mfie_q[m] <= wdata_q[`FCI_CTLP_MFIE];
            end
            if (is_mod_reg(aw_idx_q, `FCI_IDX_SINC0, m)) begin
               ae_q[m] <= wdata_q[`FCI_SINC_AE];
            end
            if (is_mod_reg(aw_idx_q, `FCI_IDX_CMP0, m)) begin
               ieh_q[m] <= wdata_q[`FCI_CMP_IEH];
               iel_q[m] <= wdata_q[`FCI_CMP_IEL];
            end
         end
      end
   end

   //****************************************************************
   // pattern generator
   //****************************************************************
   logic [PAT_LEN-1:0] pattern_q;
   logic [7:0] div_cnt_q;
   logic [PW-1:0] ptr_q;
   logic tick;
   logic [7:0] div_last;
   logic carrier_q;
   logic comp_q;
   logic gen_bit;

   // a divider of zero behaves as one so the generator never stalls
   assign div_last = (div == 8'h00) ? 8'h00 : 8'(div - 8'h01);
   assign tick = pattern_gen_enable && (div_cnt_q == div_last);
   assign gen_bit = pattern_q[ptr_q];

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pattern_q <= '0;
      end else if (do_wr && aw_idx_q == `FCI_IDX_PAT) begin
         pattern_q <= {pattern_q[PAT_LEN-`FCI_PAT_WORD-1:0], wdata_q[15:0]};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || !pattern_gen_enable || tick) begin
         div_cnt_q <= 8'h00;
      end else begin
         div_cnt_q <= 8'(div_cnt_q + 8'h01);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ptr_q <= '0;
      end else if (!pattern_gen_enable) begin
         ptr_q <= plen;
      end else if (tick) begin
         ptr_q <= (ptr_q == '0) ? plen : PW'(ptr_q - 1'b1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         carrier_q <= 1'b0;
         comp_q <= 1'b1;
      end else begin
         carrier_q <= pattern_gen_enable & gen_bit;
         comp_q <= ~(pattern_gen_enable & gen_bit);
      end
   end

   assign carrier_out_true = carrier_q;
   assign carrier_out_comp = comp_q;

   //****************************************************************
   // phase calibration
   //****************************************************************
   fci_cal_t cal_q;
   logic phase_cal_bit_q;
   logic [PW:0] cal_cnt_q;
   logic [PW-1:0] offset_q;
   logic filt_pol_q;
   logic filt_rise;
   logic phase_cal_bit_wr;
   logic [PW:0] dm_sum;
   logic [PW-1:0] dm_idx;
   logic demod_q;

   assign filt_rise = filt_polarity & ~filt_pol_q;
   assign phase_cal_bit_wr = do_wr && aw_idx_q == `FCI_IDX_CLKDIV && wstrb_q[1];

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         filt_pol_q <= 1'b0;
      end else begin
         filt_pol_q <= filt_polarity;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cal_q <= CAL_IDLE;
         phase_cal_bit_q <= 1'b0;
         cal_cnt_q <= '0;
         offset_q <= '0;
      end else if (phase_cal_bit_wr && !wdata_q[`FCI_CLKDIV_PHASE_CAL_BIT]) begin
         cal_q <= CAL_IDLE;
         phase_cal_bit_q <= 1'b0;
      end else if (phase_cal_bit_wr && cal_q == CAL_IDLE) begin
         cal_q <= CAL_RUN;
         phase_cal_bit_q <= 1'b1;
         cal_cnt_q <= '0;
      end else begin
         unique case (cal_q)
            CAL_IDLE: begin
            end
            CAL_RUN: begin
               if (pattern_gen_enable && filt_rise) begin
                  offset_q <= ptr_q;
                  phase_cal_bit_q <= 1'b0;
                  cal_q <= CAL_IDLE;
               end else if (tick) begin
                  if (cal_cnt_q == {1'b0, plen}) begin
                     cal_q <= CAL_FAIL;
                  end
                  cal_cnt_q <= (PW + 1)'(cal_cnt_q + 1'b1);
               end
            end
            CAL_FAIL: begin
            end
         endcase
      end
   end

   // reference is the pattern rotated so its start lines up with the filter's rising polarity
   assign dm_sum = (PW + 1)'({1'b0, ptr_q} + {1'b0, plen} - {1'b0, offset_q});
   assign dm_idx = (dm_sum > {1'b0, plen}) ? PW'(dm_sum - {1'b0, plen} - 1'b1) : dm_sum[PW-1:0];

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         demod_q <= 1'b0;
      end else begin
         demod_q <= pattern_gen_enable & pattern_q[dm_idx];
      end
   end

   assign demod_ref = demod_q;

   //****************************************************************
   // modulator clock watchdog
   //****************************************************************
   logic [N_MOD-1:0] mclk_s1_q;
   logic [N_MOD-1:0] mclk_s2_q;
   logic [N_MOD-1:0] mclk_d_q;
   logic [N_MOD-1:0] clk_fail;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mclk_s1_q <= '0;
         mclk_s2_q <= '0;
         mclk_d_q <= '0;
      end else begin
         mclk_s1_q <= mod_clk;
         mclk_s2_q <= mclk_s1_q;
         mclk_d_q <= mclk_s2_q;
      end
   end

   genvar g;
   generate
      for (g = 0; g < N_MOD; g++) begin : g_wd
         logic [6:0] wd_cnt_q;
         always_ff @(posedge sys_clk) begin
            if (rst || (mclk_s2_q[g] && !mclk_d_q[g])) begin
               wd_cnt_q <= 7'h00;
            end else if (wd_cnt_q != 7'(`FCI_WD_RATIO)) begin
               wd_cnt_q <= 7'(wd_cnt_q + 7'h01);
            end
         end
         assign clk_fail[g] = (wd_cnt_q == 7'(`FCI_WD_RATIO));
      end
   endgenerate

   //****************************************************************
   // interrupt and acknowledge flags
   //****************************************************************
   logic [2*N_MOD-1:0] cmp_flag_q;
   logic [N_MOD-1:0] mf_q;
   logic [N_MOD-1:0] af_q;
   logic [2*N_MOD-1:0] cmp_src;
   logic [2*N_MOD-1:0] cmp_en;
   logic irq_rd;
   logic [N_MOD-1:0] data_rd;
   logic [N_MOD-1:0] af_set;
   logic irq_q;
   logic ack_q;

   assign irq_rd = do_rd && rd_idx == `FCI_IDX_IRQ;

   always_comb begin
      cmp_src = '0;
      cmp_en = '0;
      data_rd = '0;
      for (int m = 0; m < N_MOD; m++) begin
         cmp_src[2*m] = high_cmp_hit[m];
         cmp_src[2*m+1] = low_cmp_hit[m];
         cmp_en[2*m] = ieh_q[m];
         cmp_en[2*m+1] = iel_q[m];
         data_rd[m] = do_rd && rd_idx == 7'(`FCI_IDX_DATA0 + 7'(m) * `FCI_DATA_STRIDE);
      end
   end

   assign af_set = data_new & ae_q & (filt_enabled | integ_enabled) & ~osr_both_one;

   // a set in the clearing cycle wins, since the set term is ored in last
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cmp_flag_q <= '0;
         mf_q <= '0;
         af_q <= '0;
      end else begin
         cmp_flag_q <= (cmp_flag_q & ~({2*N_MOD{irq_rd}} & ~cmp_src)) | (cmp_src & cmp_en & {2*N_MOD{gie}});
         mf_q <= (mf_q & ~({N_MOD{irq_rd}} & ~clk_fail)) | (clk_fail & mfie_q & {N_MOD{gie}});
         af_q <= (af_q & ~data_rd) | af_set;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_q <= 1'b0;
         ack_q <= 1'b0;
      end else begin
         irq_q <= (|{mf_q, cmp_flag_q}) ^ ctrl_q[`FCI_CTRL_IPOL];
         ack_q <= (|af_q) ^ ctrl_q[`FCI_CTRL_APOL];
      end
   end

   assign irq_output_pin = irq_q;
   assign new_data_pin = ack_q;

   //****************************************************************
   // read mux
   //****************************************************************
   always_comb begin
      rd_val = 32'h0000_0000;
      if (rd_idx == `FCI_IDX_IRQ) begin
         rd_val[15:0] = {af_q, mf_q, cmp_flag_q};
      end else if (rd_idx == `FCI_IDX_CTRL) begin
         rd_val[15:0] = ctrl_q;
      end else if (rd_idx == `FCI_IDX_CLKDIV) begin
         rd_val[9:0] = {phase_cal_bit_q, clkdiv_q};
      end
      for (int m = 0; m < N_MOD; m++) begin
         if (is_mod_reg(rd_idx, `FCI_IDX_CTLP0, m)) begin
            rd_val[`FCI_CTLP_MFIE] = mfie_q[m];
         end
         if (is_mod_reg(rd_idx, `FCI_IDX_SINC0, m)) begin
            rd_val[`FCI_SINC_AE] = ae_q[m];
         end
         if (is_mod_reg(rd_idx, `FCI_IDX_CMP0, m)) begin
            rd_val[1:0] = {iel_q[m], ieh_q[m]};
         end
         if (data_rd[m]) begin
            rd_val = data_words[32*m +: 32];
         end
      end
   end

endmodule
`default_nettype wire

// ---- fci_defines.svh ----
// offsets, field positions, reset values and timing counts of the control and interrupt block
`ifndef FCI_DEFINES_SVH
`define FCI_DEFINES_SVH
`define FCI_IDX_W 7
`define FCI_IDX_IRQ 7'h00
`define FCI_IDX_CTLP0 7'h01
`define FCI_IDX_SINC0 7'h02
`define FCI_IDX_CMP0 7'h06
`define FCI_MOD_STRIDE 7'h07
`define FCI_IDX_CTRL 7'h19
`define FCI_IDX_PAT 7'h1a
`define FCI_IDX_CLKDIV 7'h1b
`define FCI_IDX_DATA0 7'h1d
`define FCI_DATA_STRIDE 7'h02
`define FCI_CTRL_GIE 0
`define FCI_CTRL_IPOL 1
`define FCI_CTRL_APOL 2
`define FCI_CTRL_PLEN_LO 6
`define FCI_CTRL_PLEN_HI 15
`define FCI_CLKDIV_SD_HI 7
`define FCI_CLKDIV_SGE 8
`define FCI_CLKDIV_PHASE_CAL_BIT 9
`define FCI_CTLP_MFIE 0
`define FCI_SINC_AE 0
`define FCI_CMP_IEH 0
`define FCI_CMP_IEL 1
`define FCI_RST_16 16'h0000
`define FCI_PAT_WORD 16
`define FCI_WD_RATIO 64
`define FCI_RESP_OKAY 2'b00
`endif

// ---- fci_pkg.sv ----
// types of the control and interrupt block
package fci_pkg;
   typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_FAIL} fci_cal_t;
   typedef logic [15:0] fci_word16_t;
endpackage

// ---- fci_ctrl_irq_asserts.sv ----
// port assertions of the control and interrupt block
`timescale 1ns/10ps
`default_nettype none
module fci_ctrl_irq_asserts #(
   parameter int N_MOD = 4
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic [N_MOD-1:0] data_new,
   input wire logic [N_MOD-1:0] filt_enabled,
   input wire logic [N_MOD-1:0] integ_enabled,
   input wire logic [N_MOD-1:0] osr_both_one,
   input wire logic carrier_out_true,
   input wire logic carrier_out_comp,
   input wire logic new_data_pin
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   //********************
   // bus and pins
   //********************
   a_carrier_pair: assert property (carrier_out_comp == !carrier_out_true)
      else $error("carrier outputs not complementary");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid && s_axi_bresp == 2'b00)
      else $error("write response late or not okay");
   a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp == 2'b00)
      else $error("read response late or not okay");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed while waiting");
   a_arready_rule: assert property (s_axi_arready == !s_axi_rvalid)
      else $error("read address ready wrong");
   // the pin may only move after a counted data word, a read or a register write
   a_ready_cause: assert property ($changed(new_data_pin) |->
      $past(|(data_new & (filt_enabled | integ_enabled) & ~osr_both_one), 2) ||
      $past(s_axi_rvalid) || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
      else $error("data pin changed without cause");
endmodule
bind fci_ctrl_irq fci_ctrl_irq_asserts #(.N_MOD(N_MOD)) i_fci_ctrl_irq_asserts (
   .sys_clk(sys_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .data_new(data_new), .filt_enabled(filt_enabled),
   .integ_enabled(integ_enabled), .osr_both_one(osr_both_one), .carrier_out_true(carrier_out_true),
   .carrier_out_comp(carrier_out_comp), .new_data_pin(new_data_pin));
`default_nettype wire

// ---- fci_host.sv ----
// host model: axi4-lite master for register access
`timescale 1ns/10ps
`default_nettype none
module fci_host #(
   parameter int ADDR_W = 9
) (
   input wire logic sys_clk,
   output logic awvalid,
   input wire logic awready,
   output logic [ADDR_W-1:0] awaddr,
   output logic wvalid,
   input wire logic wready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   input wire logic bvalid,
   output logic bready,
   output logic arvalid,
   input wire logic arready,
   output logic [ADDR_W-1:0] araddr,
   input wire logic rvalid,
   output logic rready,
   input wire logic [31:0] rdata,
   output logic hung
);
   //********************
   // bus cycles
   //********************
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, hung} = 6'h00;
      {awaddr, araddr, wdata, wstrb} = '0;
   end
   // released address and data are inverted so nothing stale looks valid
   task automatic wr(input logic [6:0] idx, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      awvalid <= 1'b1;
      awaddr <= ADDR_W'({idx, 2'b00});
      wvalid <= 1'b1;
      wdata <= {16'h0000, d};
      wstrb <= 4'h3;
      bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            awaddr <= ~awaddr;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            wdata <= ~wdata;
         end
      end while (!(bready && bvalid) && n < 300);
      bready <= 1'b0;
      if (n >= 300) hung <= 1'b1;
   endtask
   task automatic rd(input logic [6:0] idx, output logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      arvalid <= 1'b1;
      araddr <= ADDR_W'({idx, 2'b00});
      rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (arvalid && arready) begin
            arvalid <= 1'b0;
            araddr <= ~araddr;
         end
      end while (!(rready && rvalid) && n < 300);
      d = rdata;
      rready <= 1'b0;
      if (n >= 300) hung <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ---- test_filter_ctrl_irq_carrier_gen.sv ----
// self-checking bench of the control and interrupt block
`timescale 1ns/10ps
`default_nettype none
module test_filter_ctrl_irq_carrier_gen;
   import fci_pkg::*;
   typedef struct packed {logic [3:0] h; logic [3:0] l; fci_word16_t st;} fci_row_t;
   localparam fci_row_t ROWS [6] = '{'{4'h1, 4'h0, 16'h0001}, '{4'h0, 4'h1, 16'h0002},
      '{4'h2, 4'h0, 16'h0004}, '{4'h0, 4'h8, 16'h0080}, '{4'h5, 4'h5, 16'h0033}, '{4'h8, 4'h2, 16'h0048}};
   localparam logic [19:0] PAT = 20'habeef;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic awv, awrd, wv, wrd, bv, br, arv, arrd, rv, rr, cot, coc, dref, irqp, ndp, hung, ok, m, okd, md;
   logic [8:0] awa, ara;
   logic [31:0] wd, rd, rv_d;
   logic [3:0] ws;
   logic [1:0] bre, rre;
   logic [3:0] hh = 4'h0, lh = 4'h0, mclk = 4'h0, mrun = 4'hf, dn = 4'h0, fe = 4'hf, ie = 4'h0, osr = 4'h0;
   logic fpol = 1'b0;
   logic [127:0] dw = 128'hd4d4d4d4c3c3c3c3b2b2b2b2a1a1a1a1;
   logic [3:0] cs [4] = '{4'b0001, 4'b1011, 4'b1000, 4'b0101};
   logic seq [120], seqd [120];
   int n_mismatch = 0;
   int checks = 0;
   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) mclk <= mclk ^ mrun;
   fci_ctrl_irq i_fci_ctrl_irq (.sys_clk(sys_clk), .rst(rst), .s_axi_awvalid(awv), .s_axi_awready(awrd),
      .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(ws),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bre), .s_axi_arvalid(arv), .s_axi_arready(arrd),
      .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rre),
      .high_cmp_hit(hh), .low_cmp_hit(lh), .mod_clk(mclk), .data_new(dn), .filt_enabled(fe),
      .integ_enabled(ie), .osr_both_one(osr), .data_words(dw), .filt_polarity(fpol), .carrier_out_true(cot),
      .carrier_out_comp(coc), .demod_ref(dref), .irq_output_pin(irqp), .new_data_pin(ndp));
   fci_host i_fci_host (.sys_clk(sys_clk), .awvalid(awv), .awready(awrd), .awaddr(awa), .wvalid(wv),
      .wready(wrd), .wdata(wd), .wstrb(ws), .bvalid(bv), .bready(br), .arvalid(arv), .arready(arrd),
      .araddr(ara), .rvalid(rv), .rready(rr), .rdata(rd), .hung(hung));
   //********************
   // helpers
   //********************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic put(input logic [6:0] idx, input logic [15:0] d);
      i_fci_host.wr(idx, d);
   endtask
   task automatic getc(input logic [6:0] idx, input logic [31:0] exp);
      i_fci_host.rd(idx, rv_d);
      chk(rv_d, exp, "register read");
   endtask
   // one-cycle source pulses, then room for flag and pin to settle
   task automatic pulse(input logic [3:0] h, input logic [3:0] l, input logic [3:0] d);
      hh <= h;
      lh <= l;
      dn <= d;
      cyc(1);
      {hh, lh, dn} <= 12'h000;
      cyc(3);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge sys_clk) if (hung) begin
      n_mismatch++;
      stop_test();
   end
   initial begin
      cyc(90000);
      n_mismatch++;
      stop_test();
   end
   //********************
   // scenarios
   //********************
   initial begin
      cyc(8);
      rst <= 1'b0;
      cyc(1);
      put(7'h19, 16'h0001);
      for (int k = 0; k < 4; k++) put(7'(7'h06 + 7 * k), 16'h0003);
      foreach (ROWS[i]) begin
         pulse(ROWS[i].h, ROWS[i].l, 4'h0);
         chk(irqp, 1'b1, "irq pin set");
         getc(7'h00, ROWS[i].st);
         getc(7'h00, 32'h0);
         cyc(2);
         chk(irqp, 1'b0, "irq pin clear");
      end
      $display("test table done");
      rst <= 1'b1;
      cyc(8);
      rst <= 1'b0;
      cyc(1);
      chk({cot, coc, dref, irqp, ndp}, 5'b01000, "pins after reset");
      getc(7'h00, 32'h0);
      getc(7'h19, 32'h0);
      getc(7'h40, 32'h0);
      put(7'h06, 16'h0003);
      pulse(4'h1, 4'h0, 4'h0);
      getc(7'h00, 32'h0);
      put(7'h19, 16'h0001);
      put(7'h06, 16'h0001);
      pulse(4'h0, 4'h1, 4'h0);
      getc(7'h00, 32'h0);
      hh <= 4'h1;
      cyc(3);
      getc(7'h00, 32'h1);
      getc(7'h00, 32'h1);
      chk(irqp, 1'b1, "irq pin held");
      hh <= 4'h0;
      cyc(2);
      getc(7'h00, 32'h1);
      getc(7'h00, 32'h0);
      put(7'h19, 16'h0003);
      cyc(2);
      chk(irqp, 1'b1, "irq pin inverted");
      put(7'h19, 16'h0001);
      $display("test comparator flags done");
      put(7'h08, 16'h0001);
      mrun <= 4'hd;
      cyc(80);
      getc(7'h00, 32'h0200);
      getc(7'h00, 32'h0200);
      mrun <= 4'hf;
      cyc(10);
      getc(7'h00, 32'h0200);
      getc(7'h00, 32'h0);
      $display("test watchdog done");
      put(7'h02, 16'h0001);
      pulse(4'h0, 4'h0, 4'h1);
      chk(ndp, 1'b1, "data pin set");
      getc(7'h00, 32'h1000);
      getc(7'h1d, 32'ha1a1a1a1);
      cyc(2);
      chk(ndp, 1'b0, "data pin clear");
      put(7'h19, 16'h0005);
      cyc(2);
      chk(ndp, 1'b1, "data pin inverted");
      put(7'h19, 16'h0001);
      foreach (cs[i]) begin
         {fe[0], ie[0], osr[0]} <= cs[i][3:1];
         put(7'h02, {15'h0000, cs[i][0]});
         pulse(4'h0, 4'h0, 4'h1);
         getc(7'h00, {16'h0000, 3'b000, (cs[i][3] | cs[i][2]) & !cs[i][1] & cs[i][0], 12'h000});
         getc(7'h1d, 32'ha1a1a1a1);
      end
      $display("test data ready done");
      put(7'h19, 16'h04c1);
      put(7'h1a, 16'h000a);
      put(7'h1a, 16'hbeef);
      put(7'h1b, 16'h0102);
      cyc(5);
      for (int i = 0; i < 120; i++) begin
         seq[i] = cot;
         seqd[i] = dref;
         cyc(1);
      end
      // the start phase is free, so any alignment of the 2-cycle bits is accepted
      // the reference is a rotation of the same pattern, so it is searched the same way
      ok = 1'b0;
      okd = 1'b0;
      for (int k = 0; k < 40; k++) begin
         m = 1'b1;
         md = 1'b1;
         for (int i = 0; i < 80; i++) begin
            if (seq[k + i] !== PAT[19 - (i / 2) % 20]) m = 1'b0;
            if (seqd[k + i] !== PAT[19 - (i / 2) % 20]) md = 1'b0;
         end
         ok = ok | m;
         okd = okd | md;
      end
      chk(ok, 1'b1, "carrier pattern");
      chk(okd, 1'b1, "demod pattern");
      put(7'h1b, 16'h0002);
      cyc(2);
      for (int i = 0; i < 8; i++) begin
         chk({cot, dref}, 2'b00, "carrier idle");
         cyc(1);
      end
      $display("test generator done");
      put(7'h1b, 16'h0302);
      cyc(3);
      fpol <= 1'b1;
      cyc(3);
      getc(7'h1b, 32'h0102);
      fpol <= 1'b0;
      put(7'h1b, 16'h0302);
      cyc(60);
      // once failed, a late polarity rise must not clear the bit
      fpol <= 1'b1;
      cyc(3);
      getc(7'h1b, 32'h0302);
      fpol <= 1'b0;
      put(7'h1b, 16'h0102);
      put(7'h1b, 16'h0302);
      cyc(3);
      fpol <= 1'b1;
      cyc(3);
      getc(7'h1b, 32'h0102);
      $display("test calibration done");
      stop_test();
   end
endmodule
`default_nettype wire
